/* File: core/cxb_crossbar.sv */
/*
  Peripheral pin crossbar: two routing-enable registers on the SFR port,
  a registered pin ownership table and the pin/peripheral multiplexers.
  Assumes peripherals present per-slot out/oe and take per-slot in, that
  the global enable and skip mask come from other registers on this clock,
  and that pad inputs arrive asynchronously.
*/
`timescale 1ns/10ps

module cxb_crossbar (
  // Clock and reset
  input wire logic clk,
  input wire logic sys_rst,
  // SFR register port
  input wire logic [7:0] sfr_addr,
  input wire logic sfr_wr_en,
  input wire logic [7:0] sfr_wdata,
  input wire logic sfr_rd_en,
  output logic [7:0] sfr_rdata,
  // Controls held in other registers
  input wire logic global_route_enable,
  input wire logic [cxb_pkg::PIN_COUNT-1:0] pin_skip_bits,
  input wire logic spi_nss_used,
  // Peripheral side, one entry per function slot
  input wire logic [cxb_pkg::SLOT_COUNT-1:0] fn_out,
  input wire logic [cxb_pkg::SLOT_COUNT-1:0] fn_oe,
  output logic [cxb_pkg::SLOT_COUNT-1:0] fn_in,
  // General purpose port side
  input wire logic [cxb_pkg::PIN_COUNT-1:0] gpio_out,
  input wire logic [cxb_pkg::PIN_COUNT-1:0] gpio_oe,
  output logic [cxb_pkg::PIN_COUNT-1:0] gpio_in,
  // Pads
  input wire logic [cxb_pkg::PIN_COUNT-1:0] pin_i,
  output logic [cxb_pkg::PIN_COUNT-1:0] pin_o,
  output logic [cxb_pkg::PIN_COUNT-1:0] pin_oe
);
  import cxb_pkg::*;

  cxb_alloc_if alloc_bus ();

  logic [7:0] route_a_q, route_a_d;
  logic [7:0] route_b_q, route_b_d;
  logic [7:0] rdata_q, rdata_d;
  logic [PIN_COUNT-1:0] pin_meta_q, pin_sync_q;
  logic [SLOT_COUNT-1:0] slot_ok_q, slot_ok_d;
  logic [PIN_IDX_W-1:0] slot_pin_q [SLOT_COUNT];
  logic [PIN_IDX_W-1:0] slot_pin_d [SLOT_COUNT];
  logic [PIN_COUNT-1:0] pin_owned_q, pin_owned_d;
  logic [4:0] pin_owner_q [PIN_COUNT];
  logic [4:0] pin_owner_d [PIN_COUNT];
  logic [SLOT_COUNT-1:0] slot_req;
  logic [2:0] ca_count;
  logic [PIN_COUNT-1:0] skip_seen_q; // Skip mask the owner table was built from

  // Register writes, read data and ownership table next values
  always_comb
  begin
    route_a_d = route_a_q;
    route_b_d = route_b_q;
    rdata_d = 8'h00;
    if (sfr_wr_en && sfr_addr == ADDR_ROUTE_A)
      route_a_d = sfr_wdata;
    // Bit 0 of B is reserved; hardware keeps it zero whatever is written
    if (sfr_wr_en && sfr_addr == ADDR_ROUTE_B)
      route_b_d = sfr_wdata & ROUTE_B_WMASK;
    if (sfr_rd_en && sfr_addr == ADDR_ROUTE_A)
      rdata_d = route_a_q;
    else if (sfr_rd_en && sfr_addr == ADDR_ROUTE_B)
      rdata_d = route_b_q;
    slot_ok_d = alloc_bus.slot_ok;
    pin_owned_d = '0;
    for (int p = 0; p < PIN_COUNT; p++)
      pin_owner_d[p] = '0;
    for (int s = 0; s < SLOT_COUNT; s++)
    begin
      slot_pin_d[s] = alloc_bus.slot_pin[s];
      if (alloc_bus.slot_ok[s])
      begin
        pin_owned_d[alloc_bus.slot_pin[s]] = 1'b1;
        pin_owner_d[alloc_bus.slot_pin[s]] = 5'(s);
      end
    end
  end

  // All state but the pad synchroniser clears on reset
  always_ff @(posedge clk)
  begin
    if (sys_rst)
    begin
      route_a_q <= ROUTE_A_RESET;
      route_b_q <= ROUTE_B_RESET;
      rdata_q <= 8'h00;
      slot_ok_q <= '0;
      pin_owned_q <= '0;
      skip_seen_q <= '0;
      for (int s = 0; s < SLOT_COUNT; s++)
        slot_pin_q[s] <= '0;
      for (int p = 0; p < PIN_COUNT; p++)
        pin_owner_q[p] <= '0;
    end
    else
    begin
      route_a_q <= route_a_d;
      route_b_q <= route_b_d;
      rdata_q <= rdata_d;
      slot_ok_q <= slot_ok_d;
      pin_owned_q <= pin_owned_d;
      skip_seen_q <= pin_skip_bits;
      slot_pin_q <= slot_pin_d;
      pin_owner_q <= pin_owner_d;
    end
  end

  // Pad synchroniser; only the second stage is read
  always_ff @(posedge clk)
  begin
    pin_meta_q <= pin_i;
    pin_sync_q <= pin_meta_q;
  end

  assign sfr_rdata = rdata_q;
  assign gpio_in = pin_sync_q;
  // Values 001..101 count through; six means all modules, reserved means none
  assign ca_count = (route_b_q[CA_COUNT_MSB:CA_COUNT_LSB] == CA_COUNT_RESV) ? 3'h0 :
                    route_b_q[CA_COUNT_MSB:CA_COUNT_LSB];

  // Slot requests from the routing fields, all gated by the global enable
  always_comb
  begin
    slot_req = '0;
    slot_req[SLOT_UART_TX] = route_a_q[BIT_UART];
    slot_req[SLOT_UART_RX] = route_a_q[BIT_UART];
    slot_req[SLOT_CAN_TX] = route_a_q[BIT_CAN];
    slot_req[SLOT_CAN_RX] = route_a_q[BIT_CAN];
    slot_req[SLOT_SPI_SCK] = route_a_q[BIT_SERIAL_PERIPH];
    slot_req[SLOT_SPI_MISO] = route_a_q[BIT_SERIAL_PERIPH];
    slot_req[SLOT_SPI_MOSI] = route_a_q[BIT_SERIAL_PERIPH];
    slot_req[SLOT_SPI_NSS] = route_a_q[BIT_SERIAL_PERIPH] & spi_nss_used;
    slot_req[SLOT_TW_SDA] = route_a_q[BIT_TWO_WIRE];
    slot_req[SLOT_TW_SCL] = route_a_q[BIT_TWO_WIRE];
    slot_req[SLOT_CMP0] = route_a_q[BIT_CMP0_OUT];
    slot_req[SLOT_CMP0_ASYNC] = route_a_q[BIT_CMP0_UNCLOCKED];
    slot_req[SLOT_CMP1] = route_a_q[BIT_CMP1_OUT];
    slot_req[SLOT_CMP1_ASYNC] = route_a_q[BIT_CMP1_UNCLOCKED];
    slot_req[SLOT_SYSCLK] = route_b_q[BIT_SYSCLK_OUT];
    for (int k = 0; k < CA_MODULES; k++)
      slot_req[SLOT_CA_OUT0 + k] = (3'(k) < ca_count);
    slot_req[SLOT_CA_EXT_IN] = route_b_q[BIT_CA_EXT_INPUT];
    slot_req[SLOT_TMR0_IN] = route_b_q[BIT_TIMER0_INPUT];
    slot_req[SLOT_TMR1_IN] = route_b_q[BIT_TIMER1_INPUT];
    if (!global_route_enable)
      slot_req = '0;
  end

  assign alloc_bus.slot_en = slot_req;
  assign alloc_bus.skip_bits = pin_skip_bits;

  cxb_alloc u_alloc (
    .a(alloc_bus)
  );

  // Pad drive: the unclocked comparator outputs pass straight through the mux
  always_comb
  begin
    logic tw_pin;
    tw_pin = 1'b0;
    for (int p = 0; p < PIN_COUNT; p++)
    begin
      tw_pin = pin_owned_q[p] && (pin_owner_q[p] == 5'(SLOT_TW_SDA) ||
               pin_owner_q[p] == 5'(SLOT_TW_SCL));
      if (pin_owned_q[p])
      begin
        pin_o[p] = tw_pin ? 1'b0 : fn_out[pin_owner_q[p]];
        // Two-wire pins are open drain: drive only the low level
        pin_oe[p] = tw_pin ? (fn_oe[pin_owner_q[p]] & ~fn_out[pin_owner_q[p]]) :
                    fn_oe[pin_owner_q[p]];
      end
      else
      begin
        pin_o[p] = gpio_out[p];
        pin_oe[p] = gpio_oe[p];
      end
      if (!global_route_enable)
        pin_oe[p] = 1'b0;
    end
  end

  // Peripheral inputs see their granted pin, or zero when not routed
  always_comb
  begin
    for (int s = 0; s < SLOT_COUNT; s++)
      fn_in[s] = slot_ok_q[s] ? pin_sync_q[slot_pin_q[s]] : 1'b0;
  end

  // Checks
  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);

  // The owner table lags the skip mask by a cycle, so compare with the lagged copy
  logic gap_err;
  always_comb
  begin
    logic seen_free;
    seen_free = 1'b0;
    gap_err = 1'b0;
    for (int p = 0; p < PIN_COUNT; p++)
    begin
      if (pin_owned_q[p] && p != PIN_UART_TX && p != PIN_UART_RX &&
          p != PIN_CAN_TX && p != PIN_CAN_RX && seen_free)
        gap_err = 1'b1;
      if (!pin_owned_q[p] && !skip_seen_q[p] && p != PIN_UART_TX &&
          p != PIN_UART_RX && p != PIN_CAN_TX && p != PIN_CAN_RX)
        seen_free = 1'b1;
    end
  end

  sequence s_write_a;
    sfr_wr_en && sfr_addr == ADDR_ROUTE_A;
  endsequence
  sequence s_uart_on;
    global_route_enable && route_a_q[BIT_UART];
  endsequence

  chk_disabled_quiet: assert property (!global_route_enable |-> pin_oe == '0)
    else $error("pin driven while crossbar disabled");
  chk_uart_fixed_pins: assert property (s_uart_on |=> pin_owned_q[PIN_UART_TX] &&
      pin_owner_q[PIN_UART_TX] == 5'(SLOT_UART_TX) &&
      pin_owner_q[PIN_UART_RX] == 5'(SLOT_UART_RX))
    else $error("uart not on its fixed pins");
  chk_can_fixed_pins: assert property (global_route_enable && route_a_q[BIT_CAN] |=>
      slot_pin_q[SLOT_CAN_TX] == 5'(PIN_CAN_TX) && slot_pin_q[SLOT_CAN_RX] == 5'(PIN_CAN_RX))
    else $error("can not on its fixed pins");
  chk_cmp1a_off: assert property (!route_a_q[BIT_CMP1_UNCLOCKED] |=>
      !slot_ok_q[SLOT_CMP1_ASYNC])
    else $error("unclocked comparator routed while disabled");
  chk_cex_limit: assert property ((3'(3) >= ca_count) |=> !slot_ok_q[SLOT_CA_OUT0 + 3])
    else $error("counter-array output routed past count");
  chk_tw_paired: assert property (slot_ok_q[SLOT_TW_SDA] == slot_ok_q[SLOT_TW_SCL])
    else $error("two-wire pins granted apart");
  chk_skip_honoured: assert property (1'b1 ##1 ((pin_owned_q & $past(pin_skip_bits) &
      ~32'h0000_00F0) == '0))
    else $error("skipped pin given to a function");
  chk_lowest_pin: assert property (!gap_err)
    else $error("free pin left below an assigned pin");
  chk_write_route: assert property (s_write_a |=> route_a_q == $past(sfr_wdata) ##1
      (slot_ok_q[SLOT_UART_TX] == (route_a_q[BIT_UART] && $past(global_route_enable))))
    else $error("route register write not applied");
  chk_resv_reads_zero: assert property (sfr_rd_en && sfr_addr == ADDR_ROUTE_B |=>
      sfr_rdata[0] == 1'b0)
    else $error("reserved bit reads one");
endmodule

/* File: core/cxb_pkg.sv */
/*
  Constants for the peripheral pin crossbar: register addresses, field
  positions, reset values, function slot numbers in priority order and
  the fixed pin positions.
  Assumes one system clock and an SFR-style byte register port.
*/
package cxb_pkg;

  // Pin and slot geometry
  localparam int PIN_COUNT = 32;
  localparam int PIN_IDX_W = 5;
  localparam int SLOT_COUNT = 24;

  // Register addresses and reset values
  localparam logic [7:0] ADDR_ROUTE_A = 8'hE1;
  localparam logic [7:0] ADDR_ROUTE_B = 8'hE2;
  localparam logic [7:0] ROUTE_A_RESET = 8'h00;
  localparam logic [7:0] ROUTE_B_RESET = 8'h00;
  localparam logic [7:0] ROUTE_B_WMASK = 8'hFE;

  // Field positions in periph_route_enable_a
  localparam int BIT_CMP1_UNCLOCKED = 7;
  localparam int BIT_CMP1_OUT = 6;
  localparam int BIT_CMP0_UNCLOCKED = 5;
  localparam int BIT_CMP0_OUT = 4;
  localparam int BIT_TWO_WIRE = 3;
  localparam int BIT_SERIAL_PERIPH = 2;
  localparam int BIT_CAN = 1;
  localparam int BIT_UART = 0;

  // Field positions in periph_route_enable_b
  localparam int BIT_TIMER1_INPUT = 7;
  localparam int BIT_TIMER0_INPUT = 6;
  localparam int BIT_CA_EXT_INPUT = 5;
  localparam int CA_COUNT_MSB = 4;
  localparam int CA_COUNT_LSB = 2;
  localparam int BIT_SYSCLK_OUT = 1;
  localparam logic [2:0] CA_COUNT_ALL = 3'h6;
  localparam logic [2:0] CA_COUNT_RESV = 3'h7;
  localparam int CA_MODULES = 6;

  // Function slots, highest priority first
  localparam int SLOT_UART_TX = 0;
  localparam int SLOT_UART_RX = 1;
  localparam int SLOT_CAN_TX = 2;
  localparam int SLOT_CAN_RX = 3;
  localparam int SLOT_SPI_SCK = 4;
  localparam int SLOT_SPI_MISO = 5;
  localparam int SLOT_SPI_MOSI = 6;
  localparam int SLOT_SPI_NSS = 7;
  localparam int SLOT_TW_SDA = 8;
  localparam int SLOT_TW_SCL = 9;
  localparam int SLOT_CMP0 = 10;
  localparam int SLOT_CMP0_ASYNC = 11;
  localparam int SLOT_CMP1 = 12;
  localparam int SLOT_CMP1_ASYNC = 13;
  localparam int SLOT_SYSCLK = 14;
  localparam int SLOT_CA_OUT0 = 15;
  localparam int SLOT_CA_EXT_IN = 21;
  localparam int SLOT_TMR0_IN = 22;
  localparam int SLOT_TMR1_IN = 23;
  localparam int FIRST_FREE_SLOT = 4;

  // Fixed pins of the UART and CAN
  localparam int PIN_UART_TX = 4;
  localparam int PIN_UART_RX = 5;
  localparam int PIN_CAN_TX = 6;
  localparam int PIN_CAN_RX = 7;

endpackage

/* File: core/cxb_alloc_if.sv */
/*
  Carrier between the crossbar top and its pin allocator: slot requests
  and skip mask in, per-slot pin grants out.
  Assumes both ends sit on the same clock; the grant is combinational.
*/
`timescale 1ns/10ps
interface cxb_alloc_if;
  import cxb_pkg::*;

  logic [SLOT_COUNT-1:0] slot_en;
  logic [PIN_COUNT-1:0] skip_bits;
  logic [SLOT_COUNT-1:0] slot_ok;
  logic [PIN_IDX_W-1:0] slot_pin [SLOT_COUNT];

  modport alloc (input slot_en, input skip_bits, output slot_ok, output slot_pin);
  modport user (output slot_en, output skip_bits, input slot_ok, input slot_pin);
endinterface

/* File: core/cxb_alloc.sv */
/*
  Priority pin allocator: puts the UART and CAN on their fixed pins, then walks
  the other slots from highest priority down and hands each the lowest pin not yet claimed or skipped.
  Assumes slot_en is already gated by the global enable; purely combinational.
*/
`timescale 1ns/10ps
module cxb_alloc (
  // Requests and grants
  cxb_alloc_if.alloc a
);
  import cxb_pkg::*;

  // Returns {found, index} of the lowest clear bit
  function automatic logic [PIN_IDX_W:0] lowest_free(input logic [PIN_COUNT-1:0] m);
    logic [PIN_IDX_W:0] r;
    r = '0;
    for (int p = PIN_COUNT - 1; p >= 0; p--)
    begin
      if (!m[p])
        r = {1'b1, PIN_IDX_W'(p)};
    end
    return r;
  endfunction

  // Fixed pins first, then the priority walk over the remaining slots
  always_comb
  begin
    logic [PIN_COUNT-1:0] claimed;
    logic [PIN_IDX_W:0] f1;
    logic [PIN_IDX_W:0] f2;
    claimed = a.skip_bits;
    f1 = '0;
    f2 = '0;
    a.slot_ok = '0;
    for (int s = 0; s < SLOT_COUNT; s++)
      a.slot_pin[s] = '0;
    // Fixed placement keeps the bootloader pins stable whatever else is on
    if (a.slot_en[SLOT_UART_TX])
    begin
      claimed[PIN_UART_TX] = 1'b1;
      claimed[PIN_UART_RX] = 1'b1;
      a.slot_ok[SLOT_UART_TX] = 1'b1;
      a.slot_ok[SLOT_UART_RX] = 1'b1;
      a.slot_pin[SLOT_UART_TX] = PIN_IDX_W'(PIN_UART_TX);
      a.slot_pin[SLOT_UART_RX] = PIN_IDX_W'(PIN_UART_RX);
    end
    if (a.slot_en[SLOT_CAN_TX])
    begin
      claimed[PIN_CAN_TX] = 1'b1;
      claimed[PIN_CAN_RX] = 1'b1;
      a.slot_ok[SLOT_CAN_TX] = 1'b1;
      a.slot_ok[SLOT_CAN_RX] = 1'b1;
      a.slot_pin[SLOT_CAN_TX] = PIN_IDX_W'(PIN_CAN_TX);
      a.slot_pin[SLOT_CAN_RX] = PIN_IDX_W'(PIN_CAN_RX);
    end
    for (int s = FIRST_FREE_SLOT; s < SLOT_COUNT; s++)
    begin
      if (s == SLOT_TW_SDA && a.slot_en[s])
      begin
        // Two-wire pair is granted both pins or neither
        f1 = lowest_free(claimed);
        f2 = lowest_free(claimed | (PIN_COUNT'(1) << f1[PIN_IDX_W-1:0]));
        if (f1[PIN_IDX_W] && f2[PIN_IDX_W])
        begin
          a.slot_ok[SLOT_TW_SDA] = 1'b1;
          a.slot_ok[SLOT_TW_SCL] = 1'b1;
          a.slot_pin[SLOT_TW_SDA] = f1[PIN_IDX_W-1:0];
          a.slot_pin[SLOT_TW_SCL] = f2[PIN_IDX_W-1:0];
          claimed[f1[PIN_IDX_W-1:0]] = 1'b1;
          claimed[f2[PIN_IDX_W-1:0]] = 1'b1;
        end
      end
      else if (s != SLOT_TW_SCL && a.slot_en[s])
      begin
        f1 = lowest_free(claimed);
        if (f1[PIN_IDX_W])
        begin
          a.slot_ok[s] = 1'b1;
          a.slot_pin[s] = f1[PIN_IDX_W-1:0];
          claimed[f1[PIN_IDX_W-1:0]] = 1'b1;
        end
      end
    end
  end
endmodule

/* File: dv/cxb_periph_model.sv */
/*
  Model of the peripherals and pads around the crossbar. Each function slot
  drives a fixed output value and drive request. Exactly one pad is high.
  Assumes the bench picks the high pad just after a clock edge. Pads are
  always driven, so none of them floats.
*/
`timescale 1ns/10ps
module cxb_periph_model (
  // Pad selection from the bench
  input wire logic [4:0] pad_sel,
  // Peripheral side
  output logic [cxb_pkg::SLOT_COUNT-1:0] fn_out,
  output logic [cxb_pkg::SLOT_COUNT-1:0] fn_oe,
  // Pad side
  output logic [cxb_pkg::PIN_COUNT-1:0] pin_i
);
  import cxb_pkg::*;

  // Two-wire slots hold 0 so their open-drain pins pull low; slot 23 is input only
  assign fn_out = 24'h5A3CF0;
  assign fn_oe = 24'h7FFFFF;

  // One high pad makes each grant show up on the input side
  assign pin_i = 32'h1 << pad_sel;
endmodule

/* File: dv/crossbar_peripheral_pin_enables_tb.sv */
/*
  Self-checking bench for the crossbar: register access, priority pin
  allocation, skip and global enable. The pads are scanned one at a time.
  Assumes the model drives fn_out, fn_oe and pin_i. The bench drives the rest.
*/
`timescale 1ns/10ps
module crossbar_peripheral_pin_enables_tb;
  import cxb_pkg::*;
  logic clk, sys_rst, sfr_wr_en, sfr_rd_en, global_route_enable, spi_nss_used;
  logic [7:0] sfr_addr, sfr_wdata, sfr_rdata;
  logic [PIN_COUNT-1:0] pin_skip_bits, gpio_out, gpio_oe, gpio_in, pin_i, pin_o, pin_oe;
  logic [SLOT_COUNT-1:0] fn_out, fn_oe, fn_in;
  logic [4:0] pad_sel;
  logic [7:0] rd;
  int miscompares;
  int checked;
  int own [PIN_COUNT];

  cxb_crossbar dut (.clk, .sys_rst, .sfr_addr, .sfr_wr_en, .sfr_wdata, .sfr_rd_en,
    .sfr_rdata, .global_route_enable, .pin_skip_bits, .spi_nss_used, .fn_out, .fn_oe,
    .fn_in, .gpio_out, .gpio_oe, .gpio_in, .pin_i, .pin_o, .pin_oe);

  cxb_periph_model model (.pad_sel, .fn_out, .fn_oe, .pin_i);

  // 20 MHz system clock
  initial
  begin
    clk = 1'h0;
    forever #25 clk = ~clk;
  end

  task automatic cmp_reg(input string what, input logic [7:0] exp, input logic [7:0] got);
    checked++;
    if (got !== exp)
    begin
      miscompares++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic cmp_bus(input string what, input logic [31:0] exp, input logic [31:0] got);
    checked++;
    if (got !== exp)
    begin
      miscompares++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask

  // Strobes rise just after an edge and fall after the taking edge
  task automatic sfr_write(input logic [7:0] addr, input logic [7:0] data);
    @(posedge clk);
    #2;
    sfr_addr = addr;
    sfr_wdata = data;
    sfr_wr_en = 1'h1;
    @(posedge clk);
    #2;
    sfr_wr_en = 1'h0;
  endtask

  // Read data is registered, so it is there just after the taking edge
  task automatic reg_chk(input logic [7:0] addr, input logic [7:0] exp);
    @(posedge clk);
    #2;
    sfr_addr = addr;
    sfr_rd_en = 1'h1;
    @(posedge clk);
    #2;
    sfr_rd_en = 1'h0;
    cmp_reg("sfr_rdata", exp, sfr_rdata);
    @(posedge clk);
    #2;
    cmp_reg("sfr_rdata idle", 8'h00, sfr_rdata);
  endtask

  // Program a setup, then compare pad drive and every pad's input path
  task automatic run_cfg(input string name, input logic [7:0] a, input logic [7:0] b,
    input logic [31:0] skip, input logic nss, input logic en);
    logic [23:0] req;
    logic [31:0] used;
    logic [31:0] eo;
    logic [31:0] eoe;
    int n;
    int p;
    sfr_write(ADDR_ROUTE_A, a);
    sfr_write(ADDR_ROUTE_B, b);
    global_route_enable = en;
    pin_skip_bits = skip;
    spi_nss_used = nss;
    repeat (3) @(posedge clk);
    #2;
    for (p = 0; p < 32; p++)
      own[p] = -1;
    used = skip;
    n = (b[4:2] == 3'h7) ? 0 : int'(b[4:2]);
    req = {b[7:5], 6'h00, b[1], a[7:4], {2{a[3]}}, a[2] & nss, {3{a[2]}}, 4'h0};
    for (int k = 0; k < n; k++)
      req[15+k] = 1'h1;
    // Fixed pins win even over skip bits
    if (en && a[0])
    begin
      own[4] = 0;
      own[5] = 1;
      used[5:4] = 2'h3;
    end
    if (en && a[1])
    begin
      own[6] = 2;
      own[7] = 3;
      used[7:6] = 2'h3;
    end
    for (int s = 4; s < 24; s++)
    begin
      if (s == 8 && $countones(~used) < 2)
        req[9:8] = 2'h0;
      p = 0;
      while (p < 32 && used[p])
        p++;
      if (en && req[s] && p < 32)
      begin
        own[p] = s;
        used[p] = 1'h1;
      end
    end
    // Two-wire pins are open drain and only ever pull low
    for (p = 0; p < 32; p++)
    begin
      eo[p] = gpio_out[p];
      eoe[p] = en & gpio_oe[p];
      if (own[p] == 8 || own[p] == 9)
      begin
        eo[p] = 1'h0;
        eoe[p] = fn_oe[own[p]] & ~fn_out[own[p]];
      end
      else if (own[p] >= 0)
      begin
        eo[p] = fn_out[own[p]];
        eoe[p] = fn_oe[own[p]];
      end
    end
    cmp_bus({name, " pin_oe"}, eoe, pin_oe);
    if (en)
      cmp_bus({name, " pin_o"}, eo, pin_o);
    for (p = 0; p < 32; p++)
    begin
      pad_sel = p[4:0];
      repeat (4) @(posedge clk);
      #2;
      cmp_bus({name, " gpio_in"}, 32'h1 << p, gpio_in);
      cmp_bus({name, " fn_in"}, (own[p] >= 0) ? (32'h1 << own[p]) : 32'h0, {8'h00, fn_in});
    end
    $display("test %s done", name);
  endtask

  task automatic finish_test();
    $display("comparisons %0d mismatches %0d", checked, miscompares);
    if (miscompares == 0 && checked > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask

  // Cut a hang short at about three times the expected run length
  initial
  begin
    #(50 * 4000);
    miscompares++;
    finish_test();
  end

  initial
  begin
    sys_rst = 1'h1;
    sfr_addr = 8'h00;
    sfr_wdata = 8'h00;
    sfr_wr_en = 1'h0;
    sfr_rd_en = 1'h0;
    global_route_enable = 1'h0;
    pin_skip_bits = 32'h0;
    spi_nss_used = 1'h0;
    gpio_out = 32'h55555555;
    gpio_oe = 32'h0F0F0F0F;
    pad_sel = 5'h0;
    repeat (4) @(posedge clk);
    #2;
    sys_rst = 1'h0;
    reg_chk(8'hE1, 8'h00);
    reg_chk(8'hE2, 8'h00);
    sfr_write(8'hE1, 8'hA5);
    reg_chk(8'hE1, 8'hA5);
    sfr_write(8'hE2, 8'hFA);
    reg_chk(8'hE2, 8'hFA);
    sfr_write(8'hE3, 8'h3C);
    reg_chk(8'hE3, 8'h00);
    reg_chk(8'hE1, 8'hA5);
    $display("test registers done");
    run_cfg("uart", 8'h01, 8'h00, 32'h10, 1'h0, 1'h1);
    run_cfg("spi_tw", 8'h0C, 8'h00, 32'h0, 1'h0, 1'h1);
    run_cfg("mix", 8'hF6, 8'hFA, 32'h26, 1'h1, 1'h1);
    run_cfg("starved", 8'h0C, 8'h04, 32'hFFFFFFF8, 1'h0, 1'h1);
    for (int k = 1; k < 6; k++)
      run_cfg("cex", 8'h00, {3'h0, k[2:0], 2'h0}, 32'h100, 1'h0, 1'h1);
    run_cfg("off", 8'hFF, 8'hFA, 32'h0, 1'h1, 1'h0);
    // A reset in mid-run must clear both routing registers again
    @(posedge clk);
    #2;
    sys_rst = 1'h1;
    @(posedge clk);
    #2;
    sys_rst = 1'h0;
    reg_chk(ADDR_ROUTE_A, ROUTE_A_RESET);
    reg_chk(ADDR_ROUTE_B, ROUTE_B_RESET);
    $display("test reset done");
    finish_test();
  end
endmodule
